// ==== core/fcm_port.sv ====
`timescale 1ns/1ps
module fcm_port
  import fcm_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF,
  parameter int PROG_CYCLES = PROG_CYC
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Address half pins
  input wire logic [ROW_W-1:0] mux_addr_in_i,
  input wire logic addr_half_sel_i,
  // Strobes and port clear
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic port_clear_n_i,
  // Data pins
  input wire logic [DATA_W-1:0] byte_io_i,
  output logic [DATA_W-1:0] byte_io_o,
  output logic byte_io_oe_o,
  // Controller status
  output logic ready_o
);

  localparam int COL_W = ADDR_W - ROW_W;
  localparam int DEPTH = 1 << ADDR_W;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (ADDR_W < ROW_W + 1 || ADDR_W > 2 * ROW_W)
  begin : g_bad_addr
    $error("ADDR_W must lie between 12 and 22");
  end
  if (PROG_CYCLES < 1 || PROG_CYCLES > 65535)
  begin : g_bad_prog
    $error("PROG_CYCLES must lie between 1 and 65535");
  end
  if (ABORT_CYC_USED > ABORT_CYC)
  begin : g_bad_abort
    $error("Abort path slower than allowed latency");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  fcm_pins_t pins_raw; // Pins as they arrive
  fcm_pins_t pins_s; // Pins after two flops
  fcm_pins_t prev_q; // Synced pins one edge earlier
  logic port_rst; // Device-wide clear
  logic wr_rise; // Completed bus write
  logic [ROW_W-1:0] row_q, row_d;
  logic [COL_W-1:0] col_q, col_d;
  logic [ADDR_W-1:0] addr_full; // Row forms the low bits
  fcm_mode_t mode_q, mode_d;
  fcm_pec_t pec_q, pec_d;
  logic [15:0] cnt_q, cnt_d; // Program time left
  logic [ADDR_W-1:0] tgt_addr_q, tgt_addr_d;
  logic [DATA_W-1:0] tgt_data_q, tgt_data_d;
  logic mem_we; // Array update at end of program
  logic [DATA_W-1:0] mem_q [0:DEPTH-1]; // Cell array
  logic [DATA_W-1:0] dout_q, dout_d;
  logic oe_q, oe_d;
  logic ready_q, ready_d;

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  function automatic logic [DATA_W-1:0] status_byte(input fcm_pec_t pec);
    logic [DATA_W-1:0] s;
    s = '0;
    s[ST_READY] = (pec != P_BUSY);
    s[ST_PSUSP] = (pec == P_SUSP);
    return s;
  endfunction

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------
  assign pins_raw = '{rd_n: read_strobe_n_i, wr_n: write_strobe_n_i, clr_n: port_clear_n_i,
                      half_sel: addr_half_sel_i, addr: mux_addr_in_i, data: byte_io_i};

  fcm_sync #(
    .W(PINS_W),
    .RST_VAL(PINS_IDLE)
  ) u_pin_sync (
    .ref_clk_i(ref_clk_i),
    .srst_i(srst_i),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  // Port clear acts as a full reset of the command logic
  assign port_rst = srst_i | ~pins_s.clr_n;

  // Write completes when the strobe rises while output enable stays high
  assign wr_rise = ~prev_q.wr_n & pins_s.wr_n & pins_s.rd_n & pins_s.clr_n;

  assign addr_full = {col_q, row_q};

  // Edge history kept on the synced copy only
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      prev_q <= PINS_IDLE;
    end
    else
    begin
      prev_q <= pins_s;
    end
  end

  // ----------------------------------------
  // Address halves
  // ----------------------------------------
  // Row is taken as the select falls, column as it rises again
  always_comb
  begin
    row_d = row_q;
    col_d = col_q;
    if (prev_q.half_sel && !pins_s.half_sel)
    begin
      row_d = pins_s.addr;
    end
    if (!prev_q.half_sel && pins_s.half_sel)
    begin
      col_d = pins_s.addr[COL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (port_rst)
    begin
      row_q <= '0;
      col_q <= '0;
    end
    else
    begin
      row_q <= row_d;
      col_q <= col_d;
    end
  end

  // ----------------------------------------
  // Command machine and program controller
  // ----------------------------------------
  // No protection state exists; every block accepts programming
  always_comb
  begin
    mode_d = mode_q;
    pec_d = pec_q;
    cnt_d = cnt_q;
    tgt_addr_d = tgt_addr_q;
    tgt_data_d = tgt_data_q;
    mem_we = 1'b0;
    // Program timer runs only while busy
    if (pec_q == P_BUSY)
    begin
      if (cnt_q == 16'h0001)
      begin
        mem_we = 1'b1;
        pec_d = P_IDLE;
      end
      cnt_d = cnt_q - 16'h0001;
    end
    if (wr_rise)
    begin
      unique case (pec_q)
        P_BUSY:
        begin
          // Busy: status, and suspend unless on the last count; the rest dropped
          if (pins_s.data == CMD_READ_STATUS)
          begin
            mode_d = M_STATUS;
          end
          else if (pins_s.data == CMD_SUSPEND && cnt_q != 16'h0001)
          begin
            pec_d = P_SUSP;
            mode_d = M_STATUS;
          end
        end
        P_SUSP:
        begin
          // Suspended: reads allowed, resume restarts the timer from the count left
          if (pins_s.data == CMD_RESUME)
          begin
            pec_d = P_BUSY;
            mode_d = M_STATUS;
          end
          else if (pins_s.data == CMD_READ_STATUS)
          begin
            mode_d = M_STATUS;
          end
          else if (pins_s.data == CMD_READ_ARRAY)
          begin
            mode_d = M_ARRAY;
          end
          else if (pins_s.data == CMD_READ_SIG)
          begin
            mode_d = M_SIG;
          end
        end
        P_IDLE:
        begin
          if (mode_q == M_SETUP)
          begin
            // Second write latches target and starts the controller
            tgt_addr_d = addr_full;
            tgt_data_d = pins_s.data;
            cnt_d = 16'(PROG_CYCLES);
            pec_d = P_BUSY;
            mode_d = M_STATUS;
          end
          else if (pins_s.data == CMD_READ_ARRAY)
          begin
            mode_d = M_ARRAY;
          end
          else if (pins_s.data == CMD_READ_STATUS)
          begin
            mode_d = M_STATUS;
          end
          else if (pins_s.data == CMD_READ_SIG)
          begin
            mode_d = M_SIG;
          end
          else if (pins_s.data == CMD_PROGRAM || pins_s.data == CMD_PROGRAM_ALT)
          begin
            mode_d = M_SETUP;
          end
        end
        default:
        begin
          pec_d = P_IDLE;
        end
      endcase
    end
  end

  // Clear aborts programming at once; the target byte is left unwritten and
  // must be taken as undefined by the programmer
  always_ff @(posedge ref_clk_i)
  begin
    if (port_rst)
    begin
      mode_q <= M_ARRAY;
      pec_q <= P_IDLE;
      cnt_q <= '0;
      tgt_addr_q <= '0;
      tgt_data_q <= '0;
    end
    else
    begin
      mode_q <= mode_d;
      pec_q <= pec_d;
      cnt_q <= cnt_d;
      tgt_addr_q <= tgt_addr_d;
      tgt_data_q <= tgt_data_d;
    end
  end

  // ----------------------------------------
  // Cell array
  // ----------------------------------------
  // Starts erased; there is no erase path so simulation needs this fill
  initial
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_q[i] = ERASED_BYTE;
    end
  end

  // A program can only pull bits low; a clear on the final busy edge still
  // aborts, so the cell is never written under a clear
  always_ff @(posedge ref_clk_i)
  begin
    if (mem_we && !port_rst)
    begin
      mem_q[tgt_addr_q] <= mem_q[tgt_addr_q] & tgt_data_q;
    end
  end

  // ----------------------------------------
  // Read path and pin drive
  // ----------------------------------------
  always_comb
  begin
    oe_d = ~pins_s.rd_n & pins_s.wr_n & ~port_rst;
    ready_d = (pec_q != P_BUSY);
    unique case (mode_q)
      M_ARRAY:
      begin
        dout_d = mem_q[addr_full];
      end
      M_SIG:
      begin
        dout_d = row_q[0] ? PART_CODE : MAKER_CODE;
      end
      default:
      begin
        dout_d = status_byte(pec_q);
      end
    endcase
  end

  // Data is held one edge behind the select so the pins never glitch with it
  always_ff @(posedge ref_clk_i)
  begin
    if (port_rst)
    begin
      dout_q <= '0;
      oe_q <= 1'b0;
      ready_q <= 1'b1;
    end
    else
    begin
      dout_q <= dout_d;
      oe_q <= oe_d;
      ready_q <= ready_d;
    end
  end

  assign byte_io_o = dout_q;
  assign byte_io_oe_o = oe_q;
  assign ready_o = ready_q;

endmodule // fcm_port

// ==== core/fcm_pkg.sv ====
package fcm_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 25000;      // 40 MHz reference clock
  localparam int PROG_TIME_NS = 10000;       // Byte program duration
  localparam int PROG_CYC = (PROG_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ABORT_LATENCY_NS = 100;     // Longest allowed abort time
  localparam int ABORT_CYC_RAW = (ABORT_LATENCY_NS * 1000) / CLK_PERIOD_PS;
  localparam int ABORT_CYC = (ABORT_CYC_RAW < 1) ? 1 : ABORT_CYC_RAW;
  localparam int RESET_HOLD_MIN_NS = 100;    // Least clear pulse from the programmer
  localparam int RESET_HOLD_CYC = (RESET_HOLD_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int ABORT_CYC_USED = 1;         // Abort takes effect one edge after sync

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int ROW_W = 11;                 // Multiplexed address pins
  localparam int DATA_W = 8;
  localparam int ADDR_W_DEF = 19;            // 512K bytes

  // ----------------------------------------
  // Command codes
  // ----------------------------------------
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_READ_SIG = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_PROGRAM_ALT = 8'h10;
  localparam logic [7:0] CMD_SUSPEND = 8'hB0;
  localparam logic [7:0] CMD_RESUME = 8'hD0;

  // ----------------------------------------
  // Status and identity
  // ----------------------------------------
  localparam int ST_READY = 7;               // Controller ready bit
  localparam int ST_PSUSP = 2;               // Program suspended bit
  localparam logic [7:0] MAKER_CODE = 8'hA5; // Value is arbitrary
  localparam logic [7:0] PART_CODE = 8'h5A;  // Value is arbitrary
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic rd_n;                              // Output enable, active low
    logic wr_n;                              // Write strobe, active low
    logic clr_n;                             // Port clear, active low
    logic half_sel;                          // Low: row half, high: column half
    logic [ROW_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fcm_pins_t;

  localparam int PINS_W = $bits(fcm_pins_t);
  localparam fcm_pins_t PINS_IDLE = '{rd_n: 1'b1, wr_n: 1'b1, clr_n: 1'b0, half_sel: 1'b1,
                                      addr: 11'h000, data: 8'h00};

  typedef enum logic [3:0] {
    M_ARRAY = 4'b0001,
    M_STATUS = 4'b0010,
    M_SIG = 4'b0100,
    M_SETUP = 4'b1000
  } fcm_mode_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'b001,
    P_BUSY = 3'b010,
    P_SUSP = 3'b100
  } fcm_pec_t;

endpackage

// ==== core/fcm_sync.sv ====
`timescale 1ns/1ps
module fcm_sync
  import fcm_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_q; // First stage, read only by the second
  logic [W-1:0] sync_q; // Second stage

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (srst_i)
    begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end
    else
    begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule // fcm_sync

// ==== test/fcm_port_asserts.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Pin-level checker
// ----------------------------------------
module fcm_port_asserts
  import fcm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic srst_i,
  // Programmer pins
  input wire logic [ROW_W-1:0] mux_addr_in_i,
  input wire logic addr_half_sel_i,
  input wire logic read_strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic port_clear_n_i,
  // Device outputs
  input wire logic [DATA_W-1:0] byte_io_o,
  input wire logic byte_io_oe_o,
  input wire logic ready_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (srst_i);

  a_oe_idle_float: assert property (read_strobe_n_i [*4] |-> !byte_io_oe_o)
    else $error("data pins driven with read strobe high");
  // Pins pass two sync flops, so no drive right after the strobe falls
  a_oe_read_lag: assert property ((read_strobe_n_i [*4] ##1 !read_strobe_n_i)
    |-> !byte_io_oe_o ##1 !byte_io_oe_o)
    else $error("data pins driven too early");
  a_oe_read_drive: assert property ((!read_strobe_n_i && write_strobe_n_i && port_clear_n_i) [*6]
    |-> byte_io_oe_o)
    else $error("read does not drive data pins");
  a_clear_float: assert property ((!port_clear_n_i) [*4] |-> !byte_io_oe_o)
    else $error("data pins driven during port clear");
  a_clear_abort: assert property ((!port_clear_n_i) [*4] |-> ready_o)
    else $error("controller still busy under port clear");
  // Mode and address unchanged, so the read value must hold
  a_read_stable: assert property ((!read_strobe_n_i && write_strobe_n_i && port_clear_n_i && ready_o
    && $stable(addr_half_sel_i) && $stable(mux_addr_in_i)) [*6] |-> $stable(byte_io_o))
    else $error("read data changed without a command");
  a_busy_from_write: assert property ($fell(ready_o)
    |-> $past(write_strobe_n_i, 3) && !$past(write_strobe_n_i, 6))
    else $error("controller started without a bus write");
  a_busy_min: assert property ((port_clear_n_i [*3] ##0 $fell(ready_o) ##1 port_clear_n_i [*3])
    |-> !ready_o)
    else $error("program ended too soon");

  c_prog: cover property ($fell(ready_o));
  c_read: cover property ($rose(byte_io_oe_o));
  c_abort: cover property (!port_clear_n_i && !ready_o);
endmodule // fcm_port_asserts

bind fcm_port fcm_port_asserts u_chk (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
  .mux_addr_in_i(mux_addr_in_i), .addr_half_sel_i(addr_half_sel_i), .read_strobe_n_i(read_strobe_n_i),
  .write_strobe_n_i(write_strobe_n_i), .port_clear_n_i(port_clear_n_i), .byte_io_o(byte_io_o),
  .byte_io_oe_o(byte_io_oe_o), .ready_o(ready_o));

// ==== test/fcm_prog_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Factory programmer model
// ----------------------------------------
module fcm_prog_model
  import fcm_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Resolved data bus and device drive
  input wire logic [DATA_W-1:0] bus_i,
  input wire logic oe_i,
  // Pins driven
  output fcm_pins_t pins_o
);
  // Idle: strobes high, clear released
  initial pins_o = '{rd_n: 1'b1, wr_n: 1'b1, clr_n: 1'b1, half_sel: 1'b1, addr: 11'h000, data: 8'h00};

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Row on falling select, then column on rising select
  task automatic set_addr(input logic [11:0] a);
    step(1);
    pins_o.half_sel <= 1'b0;
    pins_o.addr <= a[10:0];
    step(3);
    pins_o.half_sel <= 1'b1;
    pins_o.addr <= {10'h000, a[11]};
    step(3);
    pins_o.addr <= ~pins_o.addr;
  endtask

  // Data set up a cycle ahead, held three after the rise
  task automatic wr(input logic [7:0] d);
    step(1);
    pins_o.data <= d;
    step(1);
    pins_o.wr_n <= 1'b0;
    step(3);
    pins_o.wr_n <= 1'b1;
    step(3);
    pins_o.data <= ~d;
  endtask

  // Read strobe held long enough to cover the sync delay
  task automatic rd(output logic [7:0] d, output logic oe);
    step(1);
    pins_o.rd_n <= 1'b0;
    step(5);
    #1;
    d = bus_i;
    oe = oe_i;
    step(1);
    pins_o.rd_n <= 1'b1;
    step(4);
  endtask

  // Clear pulse never shorter than the minimum hold
  task automatic clr(input int n);
    step(1);
    pins_o.clr_n <= 1'b0;
    step(n);
    pins_o.clr_n <= 1'b1;
    step(4);
  endtask
endmodule // fcm_prog_model

// ==== test/flash_command_mux_port_test.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Testbench
// ----------------------------------------
module flash_command_mux_port_test;
  import fcm_pkg::*;
  localparam int SIM_PROG = 60; // Short, yet outlasts a command plus a read while busy
  logic ref_clk_i;
  logic srst_i;
  fcm_pins_t pins;
  logic [7:0] byte_io_o;
  logic byte_io_oe_o;
  logic ready_o;
  logic [7:0] bus;
  int num_errors;
  int tests_run;
  int busy_run;
  int last_busy;

  assign bus = byte_io_oe_o ? byte_io_o : pins.data;

  fcm_port #(.PROG_CYCLES(SIM_PROG)) uut (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .mux_addr_in_i(pins.addr), .addr_half_sel_i(pins.half_sel), .read_strobe_n_i(pins.rd_n),
    .write_strobe_n_i(pins.wr_n), .port_clear_n_i(pins.clr_n), .byte_io_i(bus),
    .byte_io_o(byte_io_o), .byte_io_oe_o(byte_io_oe_o), .ready_o(ready_o));
  fcm_prog_model m (.ref_clk_i(ref_clk_i), .bus_i(bus), .oe_i(byte_io_oe_o), .pins_o(pins));

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  // Length of the last busy stretch
  always @(posedge ref_clk_i)
  begin
    if (ready_o === 1'b0) busy_run <= busy_run + 1;
    else if (busy_run != 0)
    begin
      last_busy <= busy_run;
      busy_run <= 0;
    end
  end

  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic wait_ready;
    int n;
    n = 0;
    while (ready_o !== 1'b1 && n < 200)
    begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    if (n == 200)
    begin
      num_errors++;
      wrap_up();
    end
  endtask

  task automatic read_at(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    m.set_addr(a);
    m.rd(d, oe);
    check(8'h01, {7'h00, oe});
    check(exp, d);
  endtask

  task automatic prog(input logic [11:0] a, input logic [7:0] d);
    m.wr(CMD_PROGRAM);
    m.set_addr(a);
    m.wr(d);
    m.step(3);
    #1;
  endtask

  task automatic t_boot;
    check(8'h00, {7'h00, byte_io_oe_o});
    read_at(12'h005, ERASED_BYTE);
  endtask

  task automatic t_sig;
    m.wr(CMD_READ_SIG);
    read_at(12'h000, MAKER_CODE);
    read_at(12'h801, PART_CODE);
    read_at(12'h800, MAKER_CODE);
    m.wr(CMD_READ_STATUS);
    read_at(12'h000, 8'h80);
  endtask

  task automatic t_prog;
    prog(12'h805, 8'h3C);
    check(8'h00, {7'h00, ready_o});
    read_at(12'h805, 8'h00);
    m.wr(CMD_READ_ARRAY);
    read_at(12'h805, 8'h00);
    wait_ready();
    m.step(2);
    check(8'(SIM_PROG), 8'(last_busy));
    read_at(12'h805, 8'h80);
    m.wr(CMD_READ_ARRAY);
    read_at(12'h805, 8'h3C);
    prog(12'h805, 8'hF0);
    wait_ready();
    m.wr(CMD_READ_ARRAY);
    read_at(12'h805, 8'h30);
  endtask

  // Alternate program code, suspend, array read while suspended, resume
  task automatic t_susp;
    m.wr(CMD_PROGRAM_ALT);
    m.set_addr(12'h456);
    m.wr(8'h5A);
    m.wr(CMD_SUSPEND);
    m.step(3);
    #1;
    check(8'h01, {7'h00, ready_o});
    read_at(12'h000, 8'h84);
    m.wr(CMD_READ_ARRAY);
    read_at(12'h456, ERASED_BYTE);
    m.wr(CMD_RESUME);
    m.step(3);
    #1;
    check(8'h00, {7'h00, ready_o});
    wait_ready();
    m.wr(CMD_READ_ARRAY);
    read_at(12'h456, 8'h5A);
  endtask

  // Reset in mid-run while a program is running
  task automatic t_srst;
    prog(12'h200, 8'h00);
    check(8'h00, {7'h00, ready_o});
    @(posedge ref_clk_i);
    srst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    #1;
    check(8'h01, {7'h00, ready_o});
    check(8'h00, {7'h00, byte_io_oe_o});
    read_at(12'h200, ERASED_BYTE);
  endtask

  task automatic t_abort;
    prog(12'h123, 8'h00);
    check(8'h00, {7'h00, ready_o});
    m.clr(RESET_HOLD_CYC);
    #1;
    check(8'h01, {7'h00, ready_o});
    read_at(12'h123, ERASED_BYTE);
    // Half a program sequence, then clear: the data write must not program
    m.wr(CMD_PROGRAM);
    m.clr(RESET_HOLD_CYC);
    m.set_addr(12'h124);
    m.wr(8'h00);
    m.step(3);
    #1;
    check(8'h01, {7'h00, ready_o});
    read_at(12'h124, ERASED_BYTE);
  endtask

  initial
  begin
    num_errors = 0;
    tests_run = 0;
    busy_run = 0;
    last_busy = 0;
    srst_i = 1'b1;
    repeat (8) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    t_boot();
    t_sig();
    t_prog();
    t_susp();
    t_abort();
    t_srst();
    wrap_up();
  end
endmodule // flash_command_mux_port_test
